// [bench/core_regs_asserts.sv]
// Concurrent checks of the core register file
`timescale 1ns/1ns
module core_regs_asserts
  import core_regs_pkg::*;
(
  input wire logic       core_clk,               // Core clock
  input wire logic       rst_n,                  // Async reset
  input wire core_req_t  req,                    // Operation
  input wire logic [7:0] idx_second_q,           // Second index
  input wire logic [7:0] condition_flags_word_q, // Flags
  input wire logic [1:0] priority_level_q,       // Level
  input wire logic       int_disabled_q          // Level 3 flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic [7:0] f   = condition_flags_word_q;
  wire logic       alu = req.op inside {OP_ALU, OP_ADD, OP_SHIFT};

  chk_half_carry: assert property (req.op == OP_ADD |=>
    f[4] == $past(req.half_carry)) else $error("half carry wrong");
  chk_neg_flag: assert property (alu |=>
    f[2] == $past(req.result[7])) else $error("negative flag wrong");
  chk_zero_flag: assert property (alu |=>
    f[1] == ($past(req.result) == 8'h00)) else $error("zero flag wrong");
  chk_carry_force: assert property (
    req.op inside {OP_SET_CARRY, OP_RESET_CARRY} |=>
    f[0] == ($past(req.op) == OP_SET_CARRY)) else $error("carry wrong");
  chk_prio_level: assert property (priority_level_q ==
    (f[5] ? (f[3] ? 2'h3 : 2'h0) : (f[3] ? 2'h1 : 2'h2)))
    else $error("level does not match pair");
  chk_int_off: assert property (
    int_disabled_q == (f[5] & f[3])) else $error("disable flag wrong");
  chk_entry_prio: assert property (req.op == OP_INT_ENTRY |=>
    {f[5], f[3]} == $past(req.src_priority)) else $error("entry level");
  chk_idx_kept: assert property (
    req.op inside {OP_INT_ENTRY, OP_INT_RETURN} |=> $stable(idx_second_q))
    else $error("second index touched");
  chk_disable_lvl: assert property (req.op == OP_DISABLE_INT |=>
    int_disabled_q && priority_level_q == 2'h3) else $error("disable");
  chk_pop_restore: assert property (req.op == OP_POP_FLAGS |=>
    f == $past(req.data)) else $error("flags not restored from stack");
  cover property (req.op == OP_ADD ##1 f[4]);
  cover property (req.op == OP_INT_ENTRY ##1 !int_disabled_q);
  cover property (req.op == OP_ENABLE_INT ##1 priority_level_q == 2'h0);
endmodule : core_regs_asserts

bind cpu_core_registers_flags core_regs_asserts u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .req(req),
  .idx_second_q(idx_second_q),
  .condition_flags_word_q(condition_flags_word_q),
  .priority_level_q(priority_level_q), .int_disabled_q(int_disabled_q));

// [bench/cpu_core_registers_flags_tb.sv]
// Random and directed test of the core register file
`timescale 1ns/1ns
`include "core_regs_params.svh"
module cpu_core_registers_flags_tb
  import core_regs_pkg::*;
;
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         pc_load = 1'b0;
  logic         pc_advance = 1'b0;
  logic [15:0]  pc_in = 16'h0000;
  core_req_t    req = '0;
  core_req_t    r;
  branch_cond_t br_cond = BR_HALF;
  logic [7:0]   acc_q, x_q, y_q, f_q, s_q, e_f, e_a, e_x, e_y;
  logic [15:0]  pc_q, e_pc;
  logic [1:0]   lvl_q;
  logic         br_q, dis_q, e_br;
  int           n_errors = 0;
  int           comparisons = 0;
  integer       seed = 32'h3A9D;

  always #10 core_clk = ~core_clk;

  cpu_core_registers_flags u_cpu_core_registers_flags (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .pc_load(pc_load),
    .pc_in(pc_in), .pc_advance(pc_advance), .br_cond(br_cond),
    .acc_q(acc_q), .idx_first_q(x_q), .idx_second_q(y_q), .idx_sel_q(s_q),
    .program_counter_q(pc_q), .condition_flags_word_q(f_q),
    .branch_taken_q(br_q), .priority_level_q(lvl_q),
    .int_disabled_q(dis_q));

  function automatic logic [1:0] lvl(logic [1:0] p);
    lvl = p == 2'h3 ? 2'h3 : p == 2'h2 ? 2'h0 : p == 2'h1 ? 2'h1 : 2'h2;
  endfunction : lvl

  function automatic logic cond(logic [7:0] f, branch_cond_t c);
    case (c)
      BR_HALF:      cond = f[4];
      BR_NO_HALF:   cond = !f[4];
      BR_MINUS:     cond = f[2];
      BR_PLUS:      cond = !f[2];
      BR_EQUAL:     cond = f[1];
      BR_NOT_EQUAL: cond = !f[1];
      BR_CARRY:     cond = f[0];
      default:      cond = !f[0];
    endcase
  endfunction : cond

  function automatic logic [7:0] nf(logic [7:0] f, core_req_t q);
    case (q.op)
      OP_ALU, OP_ADD, OP_SHIFT: begin
        f[2:0] = {q.result[7], q.result == 8'h00, q.carry_out};
        if (q.op == OP_ADD) f[4] = q.half_carry;
      end
      OP_BTJ:                      f[0] = q.carry_out;
      OP_SET_CARRY:                f[0] = 1'b1;
      OP_RESET_CARRY:              f[0] = 1'b0;
      OP_ENABLE_INT, OP_HALT_WAIT: {f[5], f[3]} = 2'h2;
      OP_DISABLE_INT:              {f[5], f[3]} = 2'h3;
      OP_INT_ENTRY:                {f[5], f[3]} = q.src_priority;
      OP_INT_RETURN, OP_POP_FLAGS: f = q.data;
      OP_LOAD_REG:                 if (q.sel == SEL_FLAGS) f = q.data;
      default: ;
    endcase
    nf = f;
  endfunction : nf

  task automatic chk(logic [15:0] a, logic [15:0] e);
    comparisons++;
    if (a !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, a, e);
    end
  endtask : chk

  task automatic step;
    logic [7:0] v;
    logic [7:0] e_s;
    logic [2:0] e_l;
    logic       wr;
    v = req.op == OP_LOAD_REG ? req.data : req.result;
    wr = req.op inside {OP_LOAD_REG, OP_ALU, OP_ADD, OP_SHIFT};
    e_br = cond(e_f, br_cond);
    if (wr && req.sel == SEL_ACC) e_a = v;
    if (wr && req.sel == SEL_IDX && req.use_second_idx) e_y = v;
    if (wr && req.sel == SEL_IDX && !req.use_second_idx) e_x = v;
    if (pc_load) e_pc = pc_in;
    else if (req.op == OP_LOAD_REG && req.sel == SEL_PC_LOW)
      e_pc[7:0] = req.data;
    else if (req.op == OP_LOAD_REG && req.sel == SEL_PC_HIGH)
      e_pc[15:8] = req.data;
    else if (pc_advance) e_pc = e_pc + 16'h0001;
    e_f = nf(e_f, req);
    e_s = req.use_second_idx ? e_y : e_x;
    e_l = {&{e_f[5], e_f[3]}, lvl({e_f[5], e_f[3]})};
    @(posedge core_clk);
    #2;
    chk(f_q, e_f);
    chk(acc_q, e_a);
    chk({x_q, y_q}, {e_x, e_y});
    chk(s_q, e_s);
    chk(pc_q, e_pc);
    chk(br_q, e_br);
    chk({dis_q, lvl_q}, e_l);
  endtask : step

  task automatic do_reset;
    rst_n = 1'b0;
    req = '0;
    {e_a, e_x, e_y, e_pc, e_f} = {40'h0, `FLAGS_RESET};
    repeat (2) @(posedge core_clk);
    #2;
    chk(f_q & 8'hE8, 16'h00E8);
    chk({dis_q, lvl_q}, 16'h0007);
    rst_n = 1'b1;
  endtask : do_reset

  task automatic rand_run(int n);
    for (int i = 0; i < n; i++) begin
      r = core_req_t'(28'($random(seed)));
      r.op = core_op_t'(4'({$random(seed)} % 14));
      // Any target for results too, so index writes from the ALU occur
      r.sel = reg_sel_t'(3'({$random(seed)} % 5));
      req = r;
      pc_load = ({$random(seed)} % 8) == 0;
      pc_in = 16'($random(seed));
      pc_advance = 1'($random(seed));
      br_cond = branch_cond_t'(4'({$random(seed)} % 8));
      step();
    end
  endtask : rand_run

  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial begin
    do_reset();
    for (int k = 0; k < 2; k++) begin
      r = '0;
      r.op = OP_ADD;
      r.result = k == 0 ? 8'h00 : 8'h80;
      {r.carry_out, r.half_carry} = k == 0 ? 2'h3 : 2'h0;
      req = r;
      step();
    end
    rand_run(300);
    do_reset();
    rand_run(100);
    end_sim();
  end

  initial begin
    #100000;
    n_errors++;
    end_sim();
  end
endmodule : cpu_core_registers_flags_tb

// [design/core_regs_params.svh]
// Field positions, reset values and codes of the core register file
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH

// Condition flag field positions
`define FLAG_CARRY_POS     0
`define FLAG_ZERO_POS      1
`define FLAG_NEG_POS       2
`define FLAG_HALF_POS      4
`define FLAG_PRIO_LO_POS   3
`define FLAG_PRIO_HI_POS   5

// Unused bits of the undefined reset pattern are given zero here
`define FLAGS_RESET        8'hE8
`define ACC_RESET          8'h00
`define IDX_RESET          8'h00
`define PC_RESET           16'h0000

// Priority codes (upper, lower)
`define PRIO_LEVEL0        2'h2
`define PRIO_LEVEL1        2'h1
`define PRIO_LEVEL2        2'h0
`define PRIO_LEVEL3        2'h3

`endif

// [design/core_regs_pkg.sv]
// Types shared by the core register file
package core_regs_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ALU,
    OP_ADD,
    OP_SHIFT,
    OP_BTJ,
    OP_SET_CARRY,
    OP_RESET_CARRY,
    OP_ENABLE_INT,
    OP_DISABLE_INT,
    OP_INT_ENTRY,
    OP_INT_RETURN,
    OP_HALT_WAIT,
    OP_POP_FLAGS,
    OP_LOAD_REG
  } core_op_t;

  typedef enum logic [2:0] {
    SEL_ACC,
    SEL_IDX,
    SEL_PC_LOW,
    SEL_PC_HIGH,
    SEL_FLAGS
  } reg_sel_t;

  typedef enum logic [3:0] {
    BR_HALF,
    BR_NO_HALF,
    BR_MINUS,
    BR_PLUS,
    BR_EQUAL,
    BR_NOT_EQUAL,
    BR_CARRY,
    BR_NO_CARRY
  } branch_cond_t;

  typedef struct packed {
    core_op_t   op;
    reg_sel_t   sel;
    logic       use_second_idx;
    logic [7:0] result;
    logic       carry_out;
    logic       half_carry;
    logic [7:0] data;
    logic [1:0] src_priority;
  } core_req_t;

endpackage : core_regs_pkg

// [design/cpu_core_registers_flags.sv]
// Programmer-visible core registers and condition flags
`timescale 1ns/1ns
`include "core_regs_params.svh"

// Overview of operation
// - Five core registers, instruction access only
// - Eight-bit accumulator takes ALU results
// - Two eight-bit index registers
// - Prefix selects second index register
// - Interrupt context leaves second index alone
// - Sixteen-bit counter from two bytes
// - Flags reset to 111x1xxx pattern
// - Flags pushed, popped, bit-modified
// - Half carry from bit three
// - Branch on half carry set/clear
// - Negative flag copies result bit seven
// - Branch on minus or plus
// - Zero flag marks null result
// - Branch on equal or not equal
// - Carry set by hardware or software
// - Carry forced, tested, shifted, rotated
// - Priority pair encodes four levels
// - Interrupt entry loads source priority
// - Instructions also rewrite priority pair
module cpu_core_registers_flags
  import core_regs_pkg::*;
(
  input  wire logic         core_clk,          // 50 MHz core clock
  input  wire logic         rst_n,             // Async reset, active low
  input  wire core_req_t    req,               // Operation this cycle
  input  wire logic         pc_load,           // Load counter from pc_in
  input  wire logic [15:0]  pc_in,             // New counter value
  input  wire logic         pc_advance,        // Step counter by one
  input  wire branch_cond_t br_cond,           // Branch condition chosen
  output logic      [7:0]   acc_q,             // Accumulator
  output logic      [7:0]   idx_first_q,       // First index register
  output logic      [7:0]   idx_second_q,      // Second index register
  output logic      [7:0]   idx_sel_q,         // Index chosen by prefix
  output logic      [15:0]  program_counter_q, // Next instruction address
  output logic      [7:0]   condition_flags_word_q, // Condition flags
  output logic              branch_taken_q,    // Condition met, registered
  output logic      [1:0]   priority_level_q,  // Current software level
  output logic              int_disabled_q     // Level 3, interrupts off
);

  logic       [7:0]  flags_next;
  wire logic  [7:0]  acc_d;
  wire logic  [7:0]  idx_first_d;
  wire logic  [7:0]  idx_second_d;
  wire logic  [15:0] pc_d;
  wire logic         branch_d;
  wire logic  [1:0]  prio_pair;
  wire logic  [1:0]  level_d;
  wire logic         ld;
  wire logic         alu_like;

  function automatic logic cond_met(input branch_cond_t c,
                                    input logic [7:0] fl);
    logic r;
    r = 1'b0;
    unique case (c)
      BR_HALF:      r = fl[`FLAG_HALF_POS];
      BR_NO_HALF:   r = ~fl[`FLAG_HALF_POS];
      BR_MINUS:     r = fl[`FLAG_NEG_POS];
      BR_PLUS:      r = ~fl[`FLAG_NEG_POS];
      BR_EQUAL:     r = fl[`FLAG_ZERO_POS];
      BR_NOT_EQUAL: r = ~fl[`FLAG_ZERO_POS];
      BR_CARRY:     r = fl[`FLAG_CARRY_POS];
      BR_NO_CARRY:  r = ~fl[`FLAG_CARRY_POS];
      default:      r = 1'b0;
    endcase
    return r;
  endfunction : cond_met

  flag_update u_flag_update (
    .flags_cur  (condition_flags_word_q),
    .req        (req),
    .flags_next (flags_next)
  );

  assign ld       = (req.op == OP_LOAD_REG);
  assign alu_like = (req.op == OP_ALU) || (req.op == OP_ADD) ||
                    (req.op == OP_SHIFT);

  assign acc_d = (alu_like && req.sel == SEL_ACC) ? req.result :
                 (ld && req.sel == SEL_ACC)       ? req.data :
                                                    acc_q;

  // Index registers load or take results
  assign idx_first_d =
    ((ld || alu_like) && req.sel == SEL_IDX && !req.use_second_idx) ?
      (ld ? req.data : req.result) : idx_first_q;

  // Interrupt entry and return never write here
  assign idx_second_d =
    ((ld || alu_like) && req.sel == SEL_IDX && req.use_second_idx) ?
      (ld ? req.data : req.result) : idx_second_q;

  assign pc_d =
    pc_load                           ? pc_in :
    (ld && req.sel == SEL_PC_LOW)     ? {program_counter_q[15:8], req.data} :
    (ld && req.sel == SEL_PC_HIGH)    ? {req.data, program_counter_q[7:0]} :
    pc_advance                        ? program_counter_q + 16'h0001 :
                                        program_counter_q;

  assign branch_d = cond_met(br_cond, condition_flags_word_q);

  assign prio_pair = {flags_next[`FLAG_PRIO_HI_POS],
                      flags_next[`FLAG_PRIO_LO_POS]};
  assign level_d = (prio_pair == `PRIO_LEVEL0) ? 2'h0 :
                   (prio_pair == `PRIO_LEVEL1) ? 2'h1 :
                   (prio_pair == `PRIO_LEVEL2) ? 2'h2 : 2'h3;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q                  <= `ACC_RESET;
      idx_first_q            <= `IDX_RESET;
      idx_second_q           <= `IDX_RESET;
      idx_sel_q              <= `IDX_RESET;
      program_counter_q      <= `PC_RESET;
      condition_flags_word_q <= `FLAGS_RESET;
      branch_taken_q         <= 1'b0;
      priority_level_q       <= 2'h3;
      int_disabled_q         <= 1'b1;
    end else begin
      acc_q                  <= acc_d;
      idx_first_q            <= idx_first_d;
      idx_second_q           <= idx_second_d;
      idx_sel_q              <= req.use_second_idx ? idx_second_d
                                                   : idx_first_d;
      program_counter_q      <= pc_d;
      condition_flags_word_q <= flags_next;
      branch_taken_q         <= branch_d;
      priority_level_q       <= level_d;
      int_disabled_q         <= (prio_pair == `PRIO_LEVEL3);
    end
  end

endmodule : cpu_core_registers_flags

// [design/flag_update.sv]
// Next value of the condition flags from one operation
`timescale 1ns/1ns
`include "core_regs_params.svh"

module flag_update
  import core_regs_pkg::*;
(
  input  wire logic [7:0] flags_cur,   // Current condition flags
  input  wire core_req_t  req,         // Operation of this cycle
  output logic      [7:0] flags_next   // Updated condition flags
);

  wire logic       res_zero;
  wire logic [1:0] prio_next;
  wire logic       restore;
  wire logic       soft_load;
  logic      [7:0] f;

  assign res_zero = (req.result == 8'h00);

  assign prio_next =
    (req.op == OP_INT_ENTRY)   ? req.src_priority :
    (req.op == OP_ENABLE_INT)  ? `PRIO_LEVEL0 :
    (req.op == OP_DISABLE_INT) ? `PRIO_LEVEL3 :
    (req.op == OP_HALT_WAIT)   ? `PRIO_LEVEL0 :
    (restore || soft_load)     ? {req.data[`FLAG_PRIO_HI_POS],
                                  req.data[`FLAG_PRIO_LO_POS]} :
                                 {flags_cur[`FLAG_PRIO_HI_POS],
                                  flags_cur[`FLAG_PRIO_LO_POS]};

  // Stack restore and software load take the pair from the data word
  assign restore   = (req.op == OP_INT_RETURN) || (req.op == OP_POP_FLAGS);
  assign soft_load = (req.op == OP_LOAD_REG) && (req.sel == SEL_FLAGS);

  always_comb begin
    f = flags_cur;
    unique case (req.op)
      OP_ALU, OP_ADD, OP_SHIFT: begin
        f[`FLAG_NEG_POS] = req.result[7];
        f[`FLAG_ZERO_POS] = res_zero;
        f[`FLAG_CARRY_POS] = req.carry_out;
        if (req.op == OP_ADD) begin
          f[`FLAG_HALF_POS] = req.half_carry;
        end
      end
      OP_BTJ: f[`FLAG_CARRY_POS] = req.carry_out;
      OP_SET_CARRY: f[`FLAG_CARRY_POS] = 1'b1;
      OP_RESET_CARRY: f[`FLAG_CARRY_POS] = 1'b0;
      OP_POP_FLAGS, OP_INT_RETURN: f = req.data;
      OP_LOAD_REG: begin
        if (req.sel == SEL_FLAGS) begin
          f = req.data;
        end
      end
      default: f = flags_cur;
    endcase
    // Pair applied last so one decoder owns it for every op
    f[`FLAG_PRIO_HI_POS] = prio_next[1];
    f[`FLAG_PRIO_LO_POS] = prio_next[0];
    flags_next = f;
  end

endmodule : flag_update
